// ### rtl/tsr_pkg.sv
// Overview of operation
// - a 16-bit record whose limit is 2CH is accepted as valid
// - dispatching a 16-bit task keeps the previous page directory base
// - a 16-bit task has no I/O map base and no I/O map function
// - saving to a 16-bit record stores only low halves of flags and pointer
// - general registers through a 16-bit record keep no upper 16 bits
// - 16-bit record fields sit in 2-byte slots, link at 0 to local table at 42
// - in 64-bit mode any transfer to a record or task gate faults
// - in 64-bit mode interrupt return with nested flag set faults
// - 64-bit record gives full 64-bit stack pointers for levels 0 to 2
// - 64-bit record gives seven 64-bit stack table pointers as two halves
// - 64-bit record holds a 16-bit I/O map offset from the record start
// - 64-bit record: reserved dword at 0, stack pointers, then table entries
// - one 64-bit record serves both 64-bit and compatibility programs
// - a jump-initiated switch leaves the new task un-nested, flag cleared
package tsr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // 16-bit record layout, byte offsets
    localparam int OFF16_LINK  = 0;
    localparam int OFF16_SP0   = 2;
    localparam int OFF16_IP    = 14;
    localparam int OFF16_FLAGS = 16;
    localparam int OFF16_GPR   = 18;
    localparam int OFF16_SEL   = 34;
    localparam int OFF16_LOCAL = 42;
    localparam logic [15:0] LIM16      = 16'h002C;
    localparam logic [4:0]  SLOT_LAST  = 5'(OFF16_LOCAL / 2);
    localparam logic [4:0]  SAVE_FIRST = 5'(OFF16_IP / 2);
    localparam logic [4:0]  SAVE_LAST  = 5'((OFF16_LOCAL - 2) / 2);

    ////////////////////////////////////////////////////////////////////////////
    // 64-bit record layout, byte offsets and dword indices
    localparam int OFF64_PSP0    = 4;
    localparam int OFF64_PSP_END = 24;
    localparam int OFF64_STP1    = 36;
    localparam int OFF64_STP2_LO = 44;
    localparam int OFF64_STP5_LO = 68;
    localparam int OFF64_STP_END = 88;
    localparam int OFF64_IOMAP   = 100;
    localparam logic [4:0] DW_PSP0    = 5'(OFF64_PSP0 / 4);
    localparam logic [4:0] DW_PSP_END = 5'(OFF64_PSP_END / 4);
    localparam logic [4:0] DW_STP1    = 5'(OFF64_STP1 / 4);
    localparam logic [4:0] DW_STP_END = 5'(OFF64_STP_END / 4);
    localparam logic [4:0] DW_IOMAP   = 5'(OFF64_IOMAP / 4);
    localparam logic [4:0] STP_GAP    = 5'h03;
    localparam logic [4:0] STP_IDX0   = 5'h04;

    ////////////////////////////////////////////////////////////////////////////
    // operations, states, carriers
    typedef enum logic [2:0] {
        OP_NONE      = 3'h0,
        OP_XFER      = 3'h1,
        OP_SAVE      = 3'h2,
        OP_RETURN    = 3'h3,
        OP_LOAD_TASK = 3'h4,
        OP_STACK     = 3'h5
    } tsr_op_e;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_RD16    = 3'h1,
        ST_WR16    = 3'h3,
        ST_RD64    = 3'h2,
        ST_QRY_LO  = 3'h6,
        ST_QRY_HI  = 3'h7,
        ST_QRY_END = 3'h5
    } tsr_state_e;

    typedef struct packed {
        tsr_op_e     op;
        logic [31:0] base;
        logic [15:0] limit;
        logic        mode64;
        logic        nested;
        logic        via_jump;
        logic [3:0]  sel;
    } tsr_cmd_s;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        half;
        logic [31:0] addr;
        logic [31:0] wdata;
    } tsr_mreq_s;

endpackage

// ### rtl/tsr_mem.sv
`timescale 1ns/1ps
// local copy of the 64-bit stack pointers, registered read
module tsr_mem
    import tsr_pkg::*;
(
    // clock
    input  wire logic        sys_clk_in,
    // write port
    input  wire logic        wr_en_in,
    input  wire logic [4:0]  wr_addr_in,
    input  wire logic [31:0] wr_data_in,
    // read port
    input  wire logic [4:0]  rd_addr_in,
    output logic      [31:0] rd_data_out
);

    logic [31:0] store [0:31];

    // no reset: contents only read after a full record load
    always_ff @(posedge sys_clk_in) begin
        if (wr_en_in) begin
            store[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        rd_data_out <= store[rd_addr_in];
    end

endmodule

// ### rtl/tsr_core.sv
`timescale 1ns/1ps
module tsr_core
    import tsr_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    // command from the core
    input  wire logic        cmd_valid_in,
    input  wire tsr_cmd_s    cmd_in,
    output logic             busy_out,
    output logic             done_out,
    output logic             prot_flt_out,
    output logic             ts_fault_out,
    // loaded 16-bit fields
    output logic             ld_valid_out,
    output logic [4:0]       ld_slot_out,
    output logic [31:0]      ld_data_out,
    // save data request
    output logic             sv_req_out,
    output logic [4:0]       sv_slot_out,
    input  wire logic [31:0] sv_data_in,
    // task state results
    output logic             nested_task_flag_out,
    output logic             keep_page_dir_out,
    output logic             io_map_valid_out,
    output logic [15:0]      io_map_base_out,
    output logic             task_register_loaded_out,
    output logic [63:0]      stack_ptr_out,
    // system memory
    output tsr_mreq_s        mem_out,
    input  wire logic        mem_ack_in,
    input  wire logic [31:0] mem_rdata_in
);

    tsr_state_e  st;
    tsr_cmd_s    cmd;
    logic [4:0]  cnt;
    logic [4:0]  rd_idx;
    logic [31:0] rd_data;
    logic        mem_we;
    logic [4:0]  mem_wi;
    logic [4:0]  next_dw;
    logic [4:0]  qry_idx;
    logic        qry_bad;

    ////////////////////////////////////////////////////////////////////////////
    // address helpers
    always_comb begin
        // reserved dwords are never fetched
        if (cnt == DW_PSP_END) begin
            next_dw = DW_STP1;
        end else if (cnt == DW_STP_END) begin
            next_dw = DW_IOMAP;
        end else begin
            next_dw = cnt + 5'h01;
        end
    end

    // stack pointers land at 0..5, table entries at 6..19
    assign mem_we = (st == ST_RD64) && mem_out.req && mem_ack_in && (cnt != DW_IOMAP);
    assign mem_wi = (cnt <= DW_PSP_END) ? cnt - DW_PSP0 : cnt - STP_GAP;

    // level 0-2, or table entry 1-7 when sel[3] is set
    always_comb begin
        if (cmd_in.sel[3]) begin
            qry_idx = {1'b0, cmd_in.sel[2:0], 1'b0} + STP_IDX0;
            qry_bad = (cmd_in.sel[2:0] == 3'h0);
        end else begin
            qry_idx = {2'h0, cmd_in.sel[1:0], 1'b0};
            qry_bad = (cmd_in.sel[1:0] == 2'h3);
        end
    end

    tsr_mem u_mem (
        .sys_clk_in  (sys_clk_in),
        .wr_en_in    (mem_we),
        .wr_addr_in  (mem_wi),
        .wr_data_in  (mem_rdata_in),
        .rd_addr_in  (rd_idx),
        .rd_data_out (rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // main sequencer
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            st           <= ST_IDLE;
            cmd          <= '0;
            cnt          <= 5'h00;
            rd_idx       <= 5'h00;
            busy_out     <= 1'b0;
            done_out     <= 1'b0;
            prot_flt_out <= 1'b0;
            ts_fault_out <= 1'b0;
            ld_valid_out <= 1'b0;
            ld_slot_out  <= 5'h00;
            ld_data_out  <= 32'h0000_0000;
            sv_req_out   <= 1'b0;
            sv_slot_out  <= 5'h00;
            mem_out      <= '0;
        end else begin
            // pulses default low
            done_out     <= 1'b0;
            prot_flt_out <= 1'b0;
            ts_fault_out <= 1'b0;
            ld_valid_out <= 1'b0;
            sv_req_out   <= 1'b0;
            case (st)
                ST_IDLE: begin
                    if (cmd_valid_in) begin
                        cmd <= cmd_in;
                        case (cmd_in.op)
                            OP_XFER: begin
                                if (cmd_in.mode64) begin
                                    prot_flt_out <= 1'b1;
                                end else if (cmd_in.limit < LIM16) begin
                                    ts_fault_out <= 1'b1;
                                end else begin
                                    st            <= ST_RD16;
                                    busy_out      <= 1'b1;
                                    cnt           <= 5'h00;
                                    mem_out.req   <= 1'b1;
                                    mem_out.we    <= 1'b0;
                                    mem_out.half  <= 1'b1;
                                    mem_out.addr  <= cmd_in.base;
                                end
                            end
                            OP_SAVE: begin
                                if (cmd_in.limit < LIM16) begin
                                    ts_fault_out <= 1'b1;
                                end else begin
                                    st          <= ST_WR16;
                                    busy_out    <= 1'b1;
                                    cnt         <= SAVE_FIRST;
                                    sv_req_out  <= 1'b1;
                                    sv_slot_out <= SAVE_FIRST;
                                end
                            end
                            OP_RETURN: begin
                                if (cmd_in.mode64 && cmd_in.nested) begin
                                    prot_flt_out <= 1'b1;
                                end else begin
                                    done_out <= 1'b1;
                                end
                            end
                            OP_LOAD_TASK: begin
                                st            <= ST_RD64;
                                busy_out      <= 1'b1;
                                cnt           <= DW_PSP0;
                                mem_out.req   <= 1'b1;
                                mem_out.we    <= 1'b0;
                                mem_out.half  <= 1'b0;
                                mem_out.addr  <= cmd_in.base + {25'h0, DW_PSP0, 2'b00};
                            end
                            OP_STACK: begin
                                // same record whatever the code width
                                if (!task_register_loaded_out || qry_bad) begin
                                    ts_fault_out <= 1'b1;
                                end else begin
                                    st       <= ST_QRY_LO;
                                    busy_out <= 1'b1;
                                    rd_idx   <= qry_idx;
                                end
                            end
                            default: begin
                                done_out <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_RD16: begin
                    if (mem_ack_in) begin
                        ld_valid_out <= 1'b1;
                        ld_slot_out  <= cnt;
                        ld_data_out  <= {16'h0000, mem_rdata_in[15:0]};
                        if (cnt == SLOT_LAST) begin
                            st          <= ST_IDLE;
                            busy_out    <= 1'b0;
                            done_out    <= 1'b1;
                            mem_out.req <= 1'b0;
                        end else begin
                            cnt          <= cnt + 5'h01;
                            mem_out.addr <= cmd.base + {26'h0, cnt + 5'h01, 1'b0};
                        end
                    end
                end
                ST_WR16: begin
                    if (mem_out.req) begin
                        if (mem_ack_in) begin
                            mem_out.req <= 1'b0;
                            if (cnt == SAVE_LAST) begin
                                st       <= ST_IDLE;
                                busy_out <= 1'b0;
                                done_out <= 1'b1;
                            end else begin
                                cnt         <= cnt + 5'h01;
                                sv_req_out  <= 1'b1;
                                sv_slot_out <= cnt + 5'h01;
                            end
                        end
                    end else if (sv_req_out) begin
                        // core answers in the cycle of the request
                        mem_out.req   <= 1'b1;
                        mem_out.we    <= 1'b1;
                        mem_out.half  <= 1'b1;
                        mem_out.addr  <= cmd.base + {26'h0, cnt, 1'b0};
                        mem_out.wdata <= {16'h0000, sv_data_in[15:0]};
                    end
                end
                ST_RD64: begin
                    if (mem_ack_in) begin
                        if (cnt == DW_IOMAP) begin
                            st          <= ST_IDLE;
                            busy_out    <= 1'b0;
                            done_out    <= 1'b1;
                            mem_out.req <= 1'b0;
                        end else begin
                            cnt          <= next_dw;
                            mem_out.addr <= cmd.base + {25'h0, next_dw, 2'b00};
                        end
                    end
                end
                ST_QRY_LO: begin
                    rd_idx <= rd_idx + 5'h01;
                    st     <= ST_QRY_HI;
                end
                ST_QRY_HI: begin
                    st <= ST_QRY_END;
                end
                ST_QRY_END: begin
                    st       <= ST_IDLE;
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end
                default: begin
                    st       <= ST_IDLE;
                    busy_out <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stack pointer assembly, low half first
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            stack_ptr_out <= 64'h0;
        end else if (st == ST_QRY_HI) begin
            stack_ptr_out[31:0] <= rd_data;
        end else if (st == ST_QRY_END) begin
            stack_ptr_out[63:32] <= rd_data;
        end
    end

    // task state after a dispatch or a task register load
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            nested_task_flag_out     <= 1'b0;
            keep_page_dir_out        <= 1'b0;
            io_map_valid_out         <= 1'b0;
            io_map_base_out          <= 16'h0000;
            task_register_loaded_out <= 1'b0;
        end else if (st == ST_RD16 && mem_ack_in && cnt == SLOT_LAST) begin
            nested_task_flag_out <= !cmd.via_jump;
            keep_page_dir_out    <= 1'b1;
            io_map_valid_out     <= 1'b0;
        end else if (st == ST_RD64 && mem_ack_in && cnt == DW_IOMAP) begin
            io_map_base_out          <= mem_rdata_in[31:16];
            io_map_valid_out         <= 1'b1;
            keep_page_dir_out        <= 1'b0;
            task_register_loaded_out <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_take(tsr_op_e o);
        st == ST_IDLE && cmd_valid_in && cmd_in.op == o;
    endsequence

    sequence s_query;
        st == ST_QRY_LO ##1 st == ST_QRY_HI ##1 st == ST_QRY_END;
    endsequence

    property p_lim16_ok;
        @(posedge sys_clk_in) disable iff (reset_in)
        s_take(OP_XFER) and (!cmd_in.mode64 && cmd_in.limit == LIM16)
            |=> !ts_fault_out && st == ST_RD16;
    endproperty
    a_lim16_ok: assert property (p_lim16_ok) else $error("2CH limit refused");

    property p_lim16_short;
        @(posedge sys_clk_in) disable iff (reset_in)
        s_take(OP_SAVE) and (cmd_in.limit < LIM16) |=> ts_fault_out && st == ST_IDLE;
    endproperty
    a_lim16_short: assert property (p_lim16_short) else $error("short limit taken");

    property p_xfer64;
        @(posedge sys_clk_in) disable iff (reset_in)
        s_take(OP_XFER) and cmd_in.mode64 |=> prot_flt_out ##1 !busy_out;
    endproperty
    a_xfer64: assert property (p_xfer64) else $error("64-bit transfer not faulted");

    property p_iret64;
        @(posedge sys_clk_in) disable iff (reset_in)
        s_take(OP_RETURN) and (cmd_in.mode64 && cmd_in.nested) |=> prot_flt_out && !done_out;
    endproperty
    a_iret64: assert property (p_iret64) else $error("nested return not faulted");

    property p_dispatch16;
        @(posedge sys_clk_in) disable iff (reset_in)
        $past(st) == ST_RD16 && done_out |-> keep_page_dir_out && !io_map_valid_out;
    endproperty
    a_dispatch16: assert property (p_dispatch16) else $error("16-bit dispatch state");

    property p_jump_unnested;
        @(posedge sys_clk_in) disable iff (reset_in)
        $past(st) == ST_RD16 && done_out && cmd.via_jump |-> !nested_task_flag_out;
    endproperty
    a_jump_unnested: assert property (p_jump_unnested) else $error("jump left nested");

    property p_upper_dropped;
        @(posedge sys_clk_in) disable iff (reset_in)
        (ld_valid_out |-> ld_data_out[31:16] == 16'h0000) and
        (mem_out.req && mem_out.we |-> mem_out.wdata[31:16] == 16'h0000);
    endproperty
    a_upper_dropped: assert property (p_upper_dropped) else $error("upper half kept");

    property p_skip_reserved;
        @(posedge sys_clk_in) disable iff (reset_in)
        st == ST_RD64 && mem_out.req |-> cnt != 5'h00 && cnt != 5'h07 && cnt != 5'h08
            && cnt != 5'h17 && cnt != 5'h18;
    endproperty
    a_skip_reserved: assert property (p_skip_reserved) else $error("reserved fetched");

    property p_query;
        @(posedge sys_clk_in) disable iff (reset_in)
        s_take(OP_STACK) and (task_register_loaded_out && !qry_bad) |=> s_query ##1 done_out;
    endproperty
    a_query: assert property (p_query) else $error("stack query timing");

endmodule

// ### verification/tsr_memmodel.sv
`timescale 1ns/1ps
// system memory holding the task state records, random wait states
module tsr_memmodel
    import tsr_pkg::*;
(
    // clock
    input  wire logic        sys_clk_in,
    // memory port
    input  wire tsr_mreq_s   mem_in,
    output logic             ack_out,
    output logic      [31:0] rdata_out
);
    logic [7:0]  mb [0:127];
    logic        go;
    logic [31:0] junk;
    logic [6:0]  a;

    ////////////////////////////////////////////////////////////////////////////
    // stall about a third of cycles, zero-wait otherwise
    initial go = 1'b0;
    initial junk = 32'h5A5A_A5A5;
    always @(posedge sys_clk_in) begin
        go <= #1 ($urandom % 3) != 0;
        junk <= ~junk;
    end
    assign a = mem_in.addr[6:0];
    assign ack_out = mem_in.req & go;

    // little-endian slots; idle bus toggles so stale data never matches
    assign rdata_out = !ack_out ? junk : mem_in.half ? {16'h0000, mb[a+7'h1], mb[a]}
                     : {mb[a+7'h3], mb[a+7'h2], mb[a+7'h1], mb[a]};

    // halfword and dword writes land at the ack edge
    always @(posedge sys_clk_in) begin
        if (mem_in.req && mem_in.we && ack_out) begin
            mb[a] <= mem_in.wdata[7:0];
            mb[a+7'h1] <= mem_in.wdata[15:8];
            if (!mem_in.half) begin
                mb[a+7'h2] <= mem_in.wdata[23:16];
                mb[a+7'h3] <= mem_in.wdata[31:24];
            end
        end
    end
endmodule

// ### verification/task_state_segment_handling_tb.sv
`timescale 1ns/1ps
module task_state_segment_handling_tb;
    import tsr_pkg::*;
    logic        sys_clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        cmd_valid_in = 1'b0;
    tsr_cmd_s    cmd_in = '0;
    logic [31:0] sv_pat = 32'h0, sv_data_in, mem_rdata_in, ld_data_out, base;
    logic        mem_ack_in, busy_out, done_out, prot_flt_out, ts_fault_out, ld_valid_out;
    logic        sv_req_out, nested_task_flag_out, keep_page_dir_out, io_map_valid_out;
    logic        task_register_loaded_out;
    logic [4:0]  ld_slot_out, sv_slot_out;
    logic [15:0] io_map_base_out;
    logic [63:0] stack_ptr_out;
    tsr_mreq_s   mem_out;
    logic [31:0] ld [0:21];
    logic [15:0] old [0:21];
    logic [2:0]  ev;
    int          n_errors = 0, checks = 0, cycles = 0, lat, n_ld, i, s;

    always #12.5 sys_clk_in = ~sys_clk_in;
    // the core answers a save slot in the same cycle
    assign sv_data_in = sv_pat ^ {27'h0, sv_slot_out};

    tsr_core tsr_core_i (.sys_clk_in, .reset_in, .cmd_valid_in, .cmd_in, .busy_out, .done_out,
        .prot_flt_out, .ts_fault_out, .ld_valid_out, .ld_slot_out, .ld_data_out, .sv_req_out,
        .sv_slot_out, .sv_data_in, .nested_task_flag_out, .keep_page_dir_out,
        .io_map_valid_out, .io_map_base_out, .task_register_loaded_out, .stack_ptr_out,
        .mem_out, .mem_ack_in, .mem_rdata_in);
    tsr_memmodel tsr_memmodel_i (.sys_clk_in, .mem_in(mem_out), .ack_out(mem_ack_in),
        .rdata_out(mem_rdata_in));

    ////////////////////////////////////////////////////////////////////////////
    // expectations
    function automatic logic [31:0] rd32(input int off);
        return {tsr_memmodel_i.mb[off+3], tsr_memmodel_i.mb[off+2],
                tsr_memmodel_i.mb[off+1], tsr_memmodel_i.mb[off]};
    endfunction
    function automatic int sp_off(input logic [3:0] sel);
        return sel[3] ? 36 + 8 * (int'(sel[2:0]) - 1) : 4 + 8 * int'(sel[1:0]);
    endfunction

    task automatic summarize;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk_val(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic fill;
        for (int k = 0; k < 128; k++) tsr_memmodel_i.mb[k] = 8'($urandom);
    endtask
    // one command, then wait for done or a fault, collecting loaded slots
    task automatic run(input tsr_op_e op, input logic [15:0] lim, input logic m64,
                       input logic nst, input logic jump_op, input logic [3:0] sel);
        @(posedge sys_clk_in);
        #1;
        cmd_in = '{op, base, lim, m64, nst, jump_op, sel};
        cmd_valid_in = 1'b1;
        @(posedge sys_clk_in);
        #1;
        cmd_valid_in = 1'b0;
        ev = 3'h0;
        n_ld = 0;
        // fault pulses show right after the take edge, so look before waiting
        for (lat = 1; lat < 500 && ev == 3'h0; lat++) begin
            if (ld_valid_out === 1'b1 && ld_slot_out < 5'h16) begin
                ld[ld_slot_out] = ld_data_out;
                n_ld++;
            end
            ev = {done_out, prot_flt_out, ts_fault_out};
            @(posedge sys_clk_in);
            #1;
        end
        lat--;
    endtask

    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(17323));
        base = $urandom & 32'hFFFF_FF80;
        fill();
        repeat (20) @(posedge sys_clk_in);
        #1;
        reset_in = 1'b0;
        chk_val(64'({busy_out, mem_out.req, task_register_loaded_out}), 64'h0, "reset");
        // every transfer kind in 64-bit mode, and every return flavour in both modes
        for (i = 0; i < 4; i++) begin
            run(OP_XFER, 16'h002C, 1'b1, i[0], i[1], 4'h0);
            chk_val(64'({ev, lat[3:0]}), 64'h21, "xfer64 fault");
            run(OP_RETURN, 16'h002C, i[0], i[1], 1'b0, 4'h0);
            chk_val(64'(ev), (i == 3) ? 64'h2 : 64'h4, "return");
        end
        run(OP_STACK, 16'h0, 1'b1, 1'b0, 1'b0, 4'h0);
        chk_val(64'(ev), 64'h1, "stack before load");
        // 16-bit dispatch, limit at and above the minimum; never a v86 task
        for (i = 0; i < 2; i++) begin
            fill();
            run(OP_XFER, 16'h002C + 16'(i), 1'b0, 1'b0, i[0], 4'h0);
            chk_val(64'({ev, 8'(n_ld)}), 64'h416, "xfer16 done");
            for (s = 0; s < 22; s++)
                chk_val(64'(ld[s]), 64'(rd32(2 * s) & 32'hFFFF), "slot");
            chk_val(64'(nested_task_flag_out), 64'(!i[0]), "nested");
            chk_val(64'(keep_page_dir_out), 64'h1, "page dir kept");
            chk_val(64'(io_map_valid_out), 64'h0, "no io map");
        end
        // save: only low halves of the supplied words reach memory
        sv_pat = $urandom;
        for (s = 0; s < 22; s++)
            old[s] = 16'(rd32(2 * s));
        run(OP_SAVE, 16'h002C, 1'b0, 1'b0, 1'b0, 4'h0);
        chk_val(64'(ev), 64'h4, "save done");
        for (s = 0; s < 22; s++)
            chk_val(64'(16'(rd32(2 * s))), (s >= 7 && s <= 20) ? 64'((sv_pat ^ s) & 32'hFFFF)
                    : 64'(old[s]), "saved slot");
        // load the 64-bit record in 64-bit mode before the stack lookups that follow
        fill();
        run(OP_LOAD_TASK, 16'h0068, 1'b1, 1'b0, 1'b0, 4'h0);
        chk_val(64'({ev, io_map_base_out}), 64'({3'h4, 16'(rd32(100) >> 16)}),
                "io base");
        chk_val(64'({task_register_loaded_out, io_map_valid_out, keep_page_dir_out}), 64'h6,
                "load flags");
        // stack pointers and table entries, both modes share one record
        for (i = 0; i < 16; i++) begin
            if (i[3] || !i[2]) begin
                run(OP_STACK, 16'h0, i[0] ^ i[1], 1'b0, 1'b0, 4'(i));
                if (i == 3 || i == 8)
                    chk_val(64'(ev), 64'h1, "bad sel");
                else
                    chk_val({ev == 3'h4, lat[3:0], stack_ptr_out[58:0]}, {1'b1, 4'h4,
                        27'(rd32(sp_off(4'(i)) + 4)), rd32(sp_off(4'(i)))},
                        "ptr");
            end
        end
        // random limits around the minimum
        for (i = 0; i < 8; i++) begin
            s = $urandom_range(16'h0030, 16'h0028);
            run(i[0] ? OP_SAVE : OP_XFER, 16'(s), 1'b0, 1'b0, 1'b1, 4'h0);
            chk_val(64'(ev), (s < 16'h002C) ? 64'h1 : 64'h4, "limit");
        end
        summarize();
    end
endmodule
